// ### logic/smpi_pkg.sv
package smpi_pkg;
  localparam int SMPI_CLK_MHZ = 100;
  localparam int SMPI_SCLK_MAX_MHZ = 40;
  localparam int SMPI_SCLK_MIN_HALF_CYC = (SMPI_CLK_MHZ + 2 * SMPI_SCLK_MAX_MHZ - 1) / (2 * SMPI_SCLK_MAX_MHZ);
  // Host half period; well above the minimum to cover both synchroniser delays
  localparam logic [3:0] SMPI_SCLK_HALF_CYC = 4'h8;

  localparam int SMPI_ADDR_W = 14;
  localparam int SMPI_MEM_DEPTH = 16384;

  localparam logic [7:0] SMPI_OP_WREN = 8'h06;
  localparam logic [7:0] SMPI_OP_WRDI = 8'h04;
  localparam logic [7:0] SMPI_OP_RDSR = 8'h05;
  localparam logic [7:0] SMPI_OP_WRSR = 8'h01;
  localparam logic [7:0] SMPI_OP_READ = 8'h03;
  localparam logic [7:0] SMPI_OP_FREAD = 8'h0B;
  localparam logic [7:0] SMPI_OP_WRITE = 8'h02;
  localparam logic [7:0] SMPI_OP_SLEEP = 8'hB9;
  localparam logic [7:0] SMPI_OP_RDID = 8'h9F;

  // Identification bytes: maker, density, revision (values arbitrary)
  localparam logic [7:0] SMPI_ID_MAKER = 8'h5A;
  localparam logic [7:0] SMPI_ID_DENSITY = 8'h21;
  localparam logic [7:0] SMPI_ID_REV = 8'h01;

  localparam int SMPI_SR_WEL_BIT = 1;
  localparam int SMPI_SR_BP_LO = 2;
  localparam int SMPI_SR_WPEN_BIT = 7;
  localparam logic [2:0] SMPI_SR_RESET = 3'h0;

  // Pin synchroniser reset: {guard, pause, data, clock, select} all high
  localparam logic [4:0] SMPI_PIN_RESET = 5'h1F;
endpackage // smpi_pkg

// ### logic/smpi_if.sv
`timescale 1ns/1ps
interface smpi_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic hold_n;
  logic guard_n;
  logic miso_o;
  logic miso_oe_n;
  logic miso;

  // Released output line floats high through a pull-up
  assign miso = miso_oe_n ? 1'b1 : miso_o;

  modport dev (input cs_n, input sclk, input mosi, input hold_n, input guard_n,
               output miso_o, output miso_oe_n);
  modport host (output cs_n, output sclk, output mosi, output hold_n, output guard_n,
                input miso);
endinterface // smpi_if

// ### logic/smpi_device.sv
`timescale 1ns/1ps
module smpi_device (
  input wire logic clock,
  input wire logic rst_n,
  smpi_if.dev link,
  output logic wr_strobe_r,
  output logic [13:0] wr_addr_r,
  output logic [7:0] wr_data_r,
  output logic mode3_r,
  output logic standby_r
);
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDH, ST_ADDL, ST_DUMMY, ST_WDATA, ST_WSR, ST_READ, ST_IGNORE
  } smpi_dev_state_type;

  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic cs_s;
  logic sclk_s;
  logic mosi_s;
  logic hold_s;
  logic guard_s;
  logic sclk_q_r;
  logic cs_q_r;
  logic rise;
  logic fall;
  logic cs_fall;
  logic deselect;
  logic [2:0] bcnt_r;
  logic [6:0] sh_r;
  logic [7:0] in_byte;
  logic byte_done;
  smpi_dev_state_type state_r;
  smpi_dev_state_type state_nxt;
  logic [7:0] op_r;
  logic [7:0] op_cur;
  logic [13:0] addr_r;
  logic [13:0] rd_addr;
  logic [2:0] sr_r;
  logic wel_r;
  logic wrote_r;
  logic [7:0] status_byte;
  logic [1:0] id_idx_r;
  logic [1:0] id_idx_nxt;
  logic [7:0] id_byte;
  logic [7:0] ld_byte;
  logic [7:0] out_sh_r;
  logic drive_r;
  logic miso_r;
  logic oe_n_r;
  logic mem_wr;
  logic [7:0] mem [0:smpi_pkg::SMPI_MEM_DEPTH-1];

  // Pin synchronisers; nothing reads s1_r except s2_r
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_r <= smpi_pkg::SMPI_PIN_RESET;
      s2_r <= smpi_pkg::SMPI_PIN_RESET;
    end else begin
      s1_r <= {link.guard_n, link.hold_n, link.mosi, link.sclk, link.cs_n};
      s2_r <= s1_r;
    end
  end

  assign cs_s = s2_r[0];
  assign sclk_s = s2_r[1];
  assign mosi_s = s2_r[2];
  assign hold_s = s2_r[3];
  assign guard_s = s2_r[4];

  // Edge history frozen during pause so an edge made during it is seen afterwards
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclk_q_r <= 1'b0;
      cs_q_r <= 1'b1;
    end else if (hold_s) begin
      sclk_q_r <= sclk_s;
      cs_q_r <= cs_s;
    end
  end

  assign rise = hold_s && !cs_s && sclk_s && !sclk_q_r;
  assign fall = hold_s && !cs_s && !sclk_s && sclk_q_r;
  assign cs_fall = hold_s && cs_q_r && !cs_s;
  assign deselect = hold_s && cs_s;
  assign in_byte = {sh_r, mosi_s};
  assign byte_done = rise && (bcnt_r == 3'h7);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode3_r <= 1'b0;
      standby_r <= 1'b1;
    end else begin
      standby_r <= cs_s;
      if (cs_fall) begin
        mode3_r <= sclk_s;
      end
    end
  end

  // Bit shifter; static between edges, so any serial clock rate up to SMPI_SCLK_MAX_MHZ works
  always_ff @(posedge clock) begin
    if (!rst_n || deselect) begin
      bcnt_r <= 3'h0;
      sh_r <= 7'h00;
    end else if (rise) begin
      bcnt_r <= bcnt_r + 3'h1;
      sh_r <= in_byte[6:0];
    end
  end

  assign op_cur = (state_r == ST_CMD) ? in_byte : op_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_CMD: begin
        if (in_byte == smpi_pkg::SMPI_OP_RDSR || in_byte == smpi_pkg::SMPI_OP_RDID) begin
          state_nxt = ST_READ;
        end else if (in_byte == smpi_pkg::SMPI_OP_WRSR) begin
          state_nxt = ST_WSR;
        end else if (in_byte == smpi_pkg::SMPI_OP_READ || in_byte == smpi_pkg::SMPI_OP_FREAD ||
                     in_byte == smpi_pkg::SMPI_OP_WRITE) begin
          state_nxt = ST_ADDH;
        end else begin
          state_nxt = ST_IGNORE;
        end
      end
      ST_ADDH: state_nxt = ST_ADDL;
      ST_ADDL: begin
        if (op_r == smpi_pkg::SMPI_OP_FREAD) begin
          state_nxt = ST_DUMMY;
        end else if (op_r == smpi_pkg::SMPI_OP_WRITE) begin
          state_nxt = ST_WDATA;
        end else begin
          state_nxt = ST_READ;
        end
      end
      ST_DUMMY: state_nxt = ST_READ;
      ST_WDATA: state_nxt = ST_WDATA;
      ST_WSR: state_nxt = ST_IGNORE;
      ST_READ: state_nxt = ST_READ;
      ST_IGNORE: state_nxt = ST_IGNORE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n || deselect) begin
      state_r <= ST_CMD;
    end else if (byte_done) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      op_r <= 8'h00;
      addr_r <= 14'h0000;
    end else if (byte_done) begin
      if (state_r == ST_CMD) begin
        op_r <= in_byte;
      end
      unique case (state_r)
        ST_ADDH: addr_r[13:8] <= in_byte[5:0];
        ST_ADDL: addr_r[7:0] <= in_byte;
        ST_WDATA: addr_r <= addr_r + 14'h0001;
        ST_READ: addr_r <= addr_r + 14'h0001;
        default: addr_r <= addr_r;
      endcase
    end
  end

  assign rd_addr = (state_r == ST_ADDL) ? {addr_r[13:8], in_byte} :
                   (state_r == ST_READ) ? addr_r + 14'h0001 : addr_r;

  // Write latch and configuration bits; latch drops when the frame ends after a write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wel_r <= 1'b0;
      wrote_r <= 1'b0;
      sr_r <= smpi_pkg::SMPI_SR_RESET;
    end else if (deselect) begin
      wrote_r <= 1'b0;
      if (wrote_r) begin
        wel_r <= 1'b0;
      end
    end else if (byte_done) begin
      if (state_r == ST_CMD && in_byte == smpi_pkg::SMPI_OP_WREN) begin
        wel_r <= 1'b1;
      end
      if (state_r == ST_CMD && in_byte == smpi_pkg::SMPI_OP_WRDI) begin
        wel_r <= 1'b0;
      end
      if (state_r == ST_WSR && wel_r && guard_s) begin
        sr_r <= {in_byte[smpi_pkg::SMPI_SR_WPEN_BIT], in_byte[smpi_pkg::SMPI_SR_BP_LO+1],
                 in_byte[smpi_pkg::SMPI_SR_BP_LO]};
        wrote_r <= 1'b1;
      end
      if (mem_wr) begin
        wrote_r <= 1'b1;
      end
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[smpi_pkg::SMPI_SR_WPEN_BIT] = sr_r[2];
    status_byte[smpi_pkg::SMPI_SR_BP_LO+1] = sr_r[1];
    status_byte[smpi_pkg::SMPI_SR_BP_LO] = sr_r[0];
    status_byte[smpi_pkg::SMPI_SR_WEL_BIT] = wel_r;
  end

  assign id_idx_nxt = (state_r == ST_CMD || id_idx_r == 2'h2) ? 2'h0 : id_idx_r + 2'h1;

  always_comb begin
    unique case (id_idx_nxt)
      2'h0: id_byte = smpi_pkg::SMPI_ID_MAKER;
      2'h1: id_byte = smpi_pkg::SMPI_ID_DENSITY;
      default: id_byte = smpi_pkg::SMPI_ID_REV;
    endcase
  end

  always_comb begin
    if (op_cur == smpi_pkg::SMPI_OP_RDSR) begin
      ld_byte = status_byte;
    end else if (op_cur == smpi_pkg::SMPI_OP_RDID) begin
      ld_byte = id_byte;
    end else begin
      ld_byte = mem[rd_addr];
    end
  end

  // Committed at the last rising edge: no busy phase to poll
  assign mem_wr = byte_done && state_r == ST_WDATA && wel_r;

  always_ff @(posedge clock) begin
    if (mem_wr) begin
      mem[addr_r] <= in_byte;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_strobe_r <= 1'b0;
      wr_addr_r <= 14'h0000;
      wr_data_r <= 8'h00;
    end else begin
      wr_strobe_r <= mem_wr;
      if (mem_wr) begin
        wr_addr_r <= addr_r;
        wr_data_r <= in_byte;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      id_idx_r <= 2'h0;
    end else if (byte_done && state_nxt == ST_READ) begin
      id_idx_r <= id_idx_nxt;
    end
  end

  // Output shifter: load at a byte boundary, present MSB at the next falling edge
  always_ff @(posedge clock) begin
    if (!rst_n || deselect) begin
      out_sh_r <= 8'h00;
      drive_r <= 1'b0;
      miso_r <= 1'b1;
    end else if (byte_done && state_nxt == ST_READ) begin
      out_sh_r <= ld_byte;
    end else if (fall && state_r == ST_READ) begin
      miso_r <= out_sh_r[7];
      out_sh_r <= {out_sh_r[6:0], 1'b0};
      drive_r <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= !(drive_r && hold_s && !cs_s);
    end
  end

  assign link.miso_o = miso_r;
  assign link.miso_oe_n = oe_n_r;
endmodule // smpi_device

// ### logic/smpi_host.sv
`timescale 1ns/1ps
module smpi_host (
  input wire logic clock,
  input wire logic rst_n,
  smpi_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready_r,
  input wire logic [7:0] cmd_op,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_len,
  input wire logic mode3,
  input wire logic hold_req,
  input wire logic guard_req,
  input wire logic tx_valid,
  output logic tx_ready_r,
  input wire logic [7:0] tx_data,
  output logic rx_valid_r,
  input wire logic rx_ready,
  output logic [7:0] rx_data_r,
  output logic busy_r
);
  typedef enum logic [2:0] {H_IDLE, H_SEL, H_LOW, H_HIGH, H_LOAD, H_END, H_DESEL} smpi_host_state_type;
  typedef enum logic [2:0] {P_OP, P_AH, P_AL, P_DM, P_DATA, P_DONE} smpi_phase_type;

  smpi_host_state_type st_r;
  smpi_phase_type ph_r;
  smpi_phase_type ph_nxt;
  logic [3:0] div_r;
  logic advance;
  logic sclk_up;
  logic cs_n_r;
  logic sclk_r;
  logic mosi_r;
  logic hold_n_r;
  logic guard_n_r;
  logic cpol_r;
  logic [7:0] op_r;
  logic [15:0] addr_r;
  logic [7:0] len_r;
  logic [2:0] bit_r;
  logic [7:0] tx_sh_r;
  logic [7:0] rx_sh_r;
  logic miso1_r;
  logic miso_s_r;
  logic rd_op;
  logic wr_op;
  logic push;
  logic pop;
  logic v1_r;
  logic [7:0] d1_r;

  assign rd_op = op_r == smpi_pkg::SMPI_OP_READ || op_r == smpi_pkg::SMPI_OP_FREAD ||
                 op_r == smpi_pkg::SMPI_OP_RDSR || op_r == smpi_pkg::SMPI_OP_RDID;
  assign wr_op = op_r == smpi_pkg::SMPI_OP_WRITE || op_r == smpi_pkg::SMPI_OP_WRSR;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      miso1_r <= 1'b1;
      miso_s_r <= 1'b1;
    end else begin
      miso1_r <= link.miso;
      miso_s_r <= miso1_r;
    end
  end

  // Divider held while paused, then a full half period, so the released output is back before sampling
  always_ff @(posedge clock) begin
    if (!rst_n || st_r == H_IDLE || st_r == H_LOAD || !hold_n_r) begin
      div_r <= 4'h0;
    end else begin
      div_r <= advance ? 4'h0 : div_r + 4'h1;
    end
  end

  assign advance = hold_n_r && (div_r == smpi_pkg::SMPI_SCLK_HALF_CYC - 4'h1);
  // Edges on which the clock line goes high; pause must not move on them
  assign sclk_up = (st_r == H_LOW && advance) || (st_r == H_END && advance && cpol_r) || (st_r == H_IDLE && mode3);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold_n_r <= 1'b1;
      guard_n_r <= 1'b1;
    end else begin
      guard_n_r <= !guard_req;
      if (!sclk_r && !sclk_up) begin
        hold_n_r <= !hold_req;
      end
    end
  end

  always_comb begin
    ph_nxt = ph_r;
    unique case (ph_r)
      P_OP: begin
        if (op_r == smpi_pkg::SMPI_OP_READ || op_r == smpi_pkg::SMPI_OP_FREAD ||
            op_r == smpi_pkg::SMPI_OP_WRITE) begin
          ph_nxt = P_AH;
        end else begin
          ph_nxt = (len_r != 8'h00) ? P_DATA : P_DONE;
        end
      end
      P_AH: ph_nxt = P_AL;
      P_AL: ph_nxt = (op_r == smpi_pkg::SMPI_OP_FREAD) ? P_DM : ((len_r != 8'h00) ? P_DATA : P_DONE);
      P_DM: ph_nxt = (len_r != 8'h00) ? P_DATA : P_DONE;
      P_DATA: ph_nxt = (len_r == 8'h01) ? P_DONE : P_DATA;
      P_DONE: ph_nxt = P_DONE;
    endcase
  end

  assign push = st_r == H_HIGH && advance && bit_r == 3'h7 && ph_r == P_DATA && rd_op;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= H_IDLE;
      ph_r <= P_OP;
      cs_n_r <= 1'b1;
      sclk_r <= 1'b0;
      mosi_r <= 1'b1;
      cpol_r <= 1'b0;
      op_r <= 8'h00;
      addr_r <= 16'h0000;
      len_r <= 8'h00;
      bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      rx_sh_r <= 8'h00;
      cmd_ready_r <= 1'b0;
      tx_ready_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      tx_ready_r <= 1'b0;
      busy_r <= st_r != H_IDLE;
      unique case (st_r)
        H_IDLE: begin
          sclk_r <= mode3;
          cmd_ready_r <= sclk_r == mode3;
          if (cmd_valid && cmd_ready_r && sclk_r == mode3) begin
            cmd_ready_r <= 1'b0;
            cpol_r <= mode3;
            op_r <= cmd_op;
            addr_r <= cmd_addr;
            len_r <= cmd_len;
            cs_n_r <= 1'b0;
            tx_sh_r <= cmd_op;
            mosi_r <= cmd_op[7];
            ph_r <= P_OP;
            bit_r <= 3'h0;
            st_r <= H_SEL;
          end
        end
        H_SEL: if (advance) begin
          sclk_r <= 1'b0;
          st_r <= H_LOW;
        end
        H_LOW: if (advance) begin
          sclk_r <= 1'b1;
          rx_sh_r <= {rx_sh_r[6:0], miso_s_r};
          st_r <= H_HIGH;
        end
        H_HIGH: if (advance) begin
          sclk_r <= 1'b0;
          if (bit_r == 3'h7) begin
            bit_r <= 3'h0;
            ph_r <= ph_nxt;
            if (ph_r == P_DATA) begin
              len_r <= len_r - 8'h01;
            end
            st_r <= H_LOAD;
          end else begin
            bit_r <= bit_r + 3'h1;
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            mosi_r <= tx_sh_r[6];
            st_r <= H_LOW;
          end
        end
        H_LOAD: begin
          // Clock held low here is how the host waits for data or buffer room
          if (ph_r == P_DONE) begin
            st_r <= H_END;
          end else if (ph_r == P_DATA && wr_op) begin
            if (tx_valid && !tx_ready_r) begin
              tx_ready_r <= 1'b1;
              tx_sh_r <= tx_data;
              mosi_r <= tx_data[7];
              st_r <= H_LOW;
            end
          end else if (ph_r == P_DATA && rd_op) begin
            if (!v1_r) begin
              tx_sh_r <= 8'h00;
              mosi_r <= 1'b0;
              st_r <= H_LOW;
            end
          end else begin
            tx_sh_r <= (ph_r == P_AH) ? addr_r[15:8] : (ph_r == P_AL) ? addr_r[7:0] : 8'h00;
            mosi_r <= (ph_r == P_AH) ? addr_r[15] : (ph_r == P_AL) ? addr_r[7] : 1'b0;
            st_r <= H_LOW;
          end
        end
        H_END: if (advance) begin
          sclk_r <= cpol_r;
          cs_n_r <= 1'b1;
          st_r <= H_DESEL;
        end
        H_DESEL: if (advance) begin
          st_r <= H_IDLE;
        end
      endcase
    end
  end

  // Two-entry receive buffer; full buffer stalls the link, not the data
  assign pop = rx_valid_r && rx_ready;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_valid_r <= 1'b0;
      rx_data_r <= 8'h00;
      v1_r <= 1'b0;
      d1_r <= 8'h00;
    end else if (push && pop) begin
      if (v1_r) begin
        rx_data_r <= d1_r;
        d1_r <= rx_sh_r;
      end else begin
        rx_data_r <= rx_sh_r;
      end
    end else if (push) begin
      if (!rx_valid_r) begin
        rx_valid_r <= 1'b1;
        rx_data_r <= rx_sh_r;
      end else begin
        v1_r <= 1'b1;
        d1_r <= rx_sh_r;
      end
    end else if (pop) begin
      rx_valid_r <= v1_r;
      rx_data_r <= d1_r;
      v1_r <= 1'b0;
    end
  end

  assign link.cs_n = cs_n_r;
  assign link.sclk = sclk_r;
  assign link.mosi = mosi_r;
  assign link.hold_n = hold_n_r;
  assign link.guard_n = guard_n_r;
endmodule // smpi_host

// ### sim/smpi_props.sv
`timescale 1ns/1ps
module smpi_props (
  input logic clock,
  input logic rst_n,
  input logic cs_n,
  input logic sclk,
  input logic mosi,
  input logic hold_n,
  input logic guard_n,
  input logic miso_o,
  input logic miso_oe_n,
  input logic miso
);
  logic [7:0] rise_cnt_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Rising clock edges inside the current frame
  always_ff @(posedge clock) begin
    if (!rst_n || cs_n) begin
      rise_cnt_r <= 8'h00;
    end else if ($rose(sclk)) begin
      rise_cnt_r <= rise_cnt_r + 8'h01;
    end
  end

  a_desel_float: assert property (cs_n [*5] |-> miso_oe_n)
    else $error("output driven while deselected");
  a_pause_float: assert property (!hold_n [*5] |-> miso_oe_n)
    else $error("output driven while paused");
  a_launch_fall: assert property (!miso_oe_n && $changed(miso_o) |-> !sclk)
    else $error("output bit changed while clock high");
  a_drive_selected: assert property ($fell(miso_oe_n) |-> !cs_n)
    else $error("output enabled without select");
  a_pause_clk_low: assert property ($changed(hold_n) |-> !sclk)
    else $error("pause changed while clock high");
  a_select_mode_steady: assert property ($fell(cs_n) |-> $stable(sclk))
    else $error("clock moved at select fall");
  a_frame_whole_bytes: assert property ($rose(cs_n) |-> rise_cnt_r[2:0] == 3'h0)
    else $error("frame ended inside a byte");
  a_data_steady_rise: assert property ($rose(sclk) && !cs_n |-> $stable(mosi))
    else $error("data input moved at a rising edge");

  c_pause_seen: cover property (!hold_n && !cs_n);
endmodule // smpi_props

// ### sim/tb_serial_memory_pin_interface.sv
`timescale 1ns/1ps
module tb_serial_memory_pin_interface;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready_r;
  logic [7:0] cmd_op = 8'h00;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_len = 8'h00;
  logic mode3 = 1'b0;
  logic hold_req = 1'b0;
  logic guard_req = 1'b0;
  logic tx_valid = 1'b0;
  logic tx_ready_r;
  logic [7:0] tx_data = 8'h00;
  logic rx_valid_r;
  logic rx_ready = 1'b0;
  logic [7:0] rx_data_r;
  logic busy_r;
  logic wr_strobe_r;
  logic [13:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic mode3_r;
  logic standby_r;
  logic [31:0] rnd = 32'h58B6CEED;
  int failures = 0;
  int n_tests = 0;
  logic [7:0] txq[$];
  logic [31:0] rxq[$];
  logic [31:0] wq[$];

  smpi_if lnk ();

  smpi_device smpi_device_i (.clock(clock), .rst_n(rst_n), .link(lnk), .wr_strobe_r(wr_strobe_r),
    .wr_addr_r(wr_addr_r), .wr_data_r(wr_data_r), .mode3_r(mode3_r), .standby_r(standby_r));

  smpi_host smpi_host_i (.clock(clock), .rst_n(rst_n), .link(lnk), .cmd_valid(cmd_valid),
    .cmd_ready_r(cmd_ready_r), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .mode3(mode3),
    .hold_req(hold_req), .guard_req(guard_req), .tx_valid(tx_valid), .tx_ready_r(tx_ready_r),
    .tx_data(tx_data), .rx_valid_r(rx_valid_r), .rx_ready(rx_ready), .rx_data_r(rx_data_r), .busy_r(busy_r));

  smpi_props smpi_props_i (.clock(clock), .rst_n(rst_n), .cs_n(lnk.cs_n), .sclk(lnk.sclk), .mosi(lnk.mosi),
    .hold_n(lnk.hold_n), .guard_n(lnk.guard_n), .miso_o(lnk.miso_o), .miso_oe_n(lnk.miso_oe_n),
    .miso(lnk.miso));

  always #5 clock = ~clock;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready_r !== 1'b1 && n < 20000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 20000) begin
      failures++;
    end
  endtask

  // One command frame; returns once the host is idle again
  task automatic cmd(input logic [7:0] op, input logic [15:0] addr, input logic [7:0] len, input logic m3);
    @(posedge clock);
    #1;
    mode3 = m3;
    repeat (4) @(posedge clock);
    #1;
    wait_ready();
    cmd_op = op;
    cmd_addr = addr;
    cmd_len = len;
    cmd_valid = 1'b1;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    wait_ready();
    check({31'h0, busy_r}, 32'h0);
  endtask

  // Transmit feed and random receive stalls
  always @(posedge clock) begin
    #1;
    if (tx_ready_r === 1'b1 && txq.size() > 0) begin
      void'(txq.pop_front());
    end
    tx_valid = txq.size() > 0;
    tx_data = (txq.size() > 0) ? txq[0] : 8'h00;
    rx_ready = rnd[0] | rnd[1];
    rnd = lfsr(rnd);
  end

  // Empty-queue pops yield an impossible note so extra results fail
  always @(posedge clock) begin
    if (rx_valid_r === 1'b1 && rx_ready === 1'b1) begin
      check({24'h000000, rx_data_r}, (rxq.size() > 0) ? rxq.pop_front() : 32'hFFFFFFFF);
    end
    if (wr_strobe_r === 1'b1) begin
      check({10'h000, wr_addr_r, wr_data_r}, (wq.size() > 0) ? wq.pop_front() : 32'hFFFFFFFF);
    end
  end

  initial begin
    #300000;
    failures++;
    results();
  end

  initial begin
    logic [15:0] a;
    logic [7:0] d0;
    logic [7:0] d1;
    repeat (2) @(posedge clock);
    #1;
    rst_n = 1'b1;
    a = rnd[15:0] | 16'hC000;
    d0 = rnd[23:16];
    d1 = rnd[31:24];
    cmd(smpi_pkg::SMPI_OP_WREN, 16'h0000, 8'h00, 1'b0);
    txq.push_back(d0);
    txq.push_back(d1);
    wq.push_back({10'h000, a[13:0], d0});
    wq.push_back({10'h000, a[13:0] + 14'h0001, d1});
    cmd(smpi_pkg::SMPI_OP_WRITE, a, 8'h02, 1'b0);
    // Pause in mid-read, mode 3
    rxq.push_back({24'h000000, d0});
    rxq.push_back({24'h000000, d1});
    fork
      begin
        repeat (450) @(posedge clock);
        #1;
        hold_req = 1'b1;
        check({31'h0, standby_r}, 32'h0);
        repeat (40) @(posedge clock);
        #1;
        hold_req = 1'b0;
      end
    join_none
    cmd(smpi_pkg::SMPI_OP_READ, a & 16'h3FFF, 8'h02, 1'b1);
    check({31'h0, mode3_r}, 32'h1);
    // Same bytes again through the dummy-byte read, mode 0
    rxq.push_back({24'h000000, d0});
    rxq.push_back({24'h000000, d1});
    cmd(smpi_pkg::SMPI_OP_FREAD, a & 16'h3FFF, 8'h02, 1'b0);
    rxq.push_back({24'h000000, smpi_pkg::SMPI_ID_MAKER});
    rxq.push_back({24'h000000, smpi_pkg::SMPI_ID_DENSITY});
    rxq.push_back({24'h000000, smpi_pkg::SMPI_ID_REV});
    cmd(smpi_pkg::SMPI_OP_RDID, 16'h0000, 8'h03, 1'b0);
    check({31'h0, mode3_r}, 32'h0);
    // Latch cleared by the earlier write: no commit expected
    txq.push_back(d1 ^ 8'hFF);
    cmd(smpi_pkg::SMPI_OP_WRITE, a ^ 16'h0055, 8'h01, 1'b0);
    // Latch set then cleared by command: no commit expected
    cmd(smpi_pkg::SMPI_OP_WREN, 16'h0000, 8'h00, 1'b0);
    cmd(smpi_pkg::SMPI_OP_WRDI, 16'h0000, 8'h00, 1'b1);
    txq.push_back(d0 ^ 8'hFF);
    cmd(smpi_pkg::SMPI_OP_WRITE, a, 8'h01, 1'b1);
    // Guarded status write refused, latch stays set
    cmd(smpi_pkg::SMPI_OP_WREN, 16'h0000, 8'h00, 1'b0);
    guard_req = 1'b1;
    txq.push_back(8'h8C);
    cmd(smpi_pkg::SMPI_OP_WRSR, 16'h0000, 8'h01, 1'b0);
    guard_req = 1'b0;
    rxq.push_back(32'h00000002);
    cmd(smpi_pkg::SMPI_OP_RDSR, 16'h0000, 8'h01, 1'b0);
    txq.push_back(8'h8C);
    cmd(smpi_pkg::SMPI_OP_WRSR, 16'h0000, 8'h01, 1'b1);
    rxq.push_back(32'h0000008C);
    cmd(smpi_pkg::SMPI_OP_RDSR, 16'h0000, 8'h01, 1'b1);
    repeat (50) @(posedge clock);
    #1;
    check({31'h0, standby_r}, 32'h1);
    check(rxq.size() + wq.size() + txq.size(), 32'h0);
    results();
  end

endmodule // tb_serial_memory_pin_interface
